// file: lcdp9_regs.vh
// lcdp9_regs.vh: offsets, reset values, field positions and mode codes for the port nine block
// assumes 16-bit register addresses and 8-bit register data
`ifndef LCDP9_REGS_VH
`define LCDP9_REGS_VH

`define LCDP9_ADDR_W          16
`define LCDP9_OFS_LATCH       16'hFFDC
`define LCDP9_OFS_DIR         16'hFFEC
`define LCDP9_LATCH_RST       8'h00
`define LCDP9_DIR_RST         8'h00
`define LCDP9_DIR_READ        8'hFF
`define LCDP9_SEG_GPIO        4'h0
`define LCDP9_PINS_EXP_HI     7
`define LCDP9_PINS_EXP_LO     4

// power modes seen on pwr_mode
`define LCDP9_MODE_ACTIVE     3'h0
`define LCDP9_MODE_SUBACTIVE  3'h1
`define LCDP9_MODE_SLEEP      3'h2
`define LCDP9_MODE_SUBSLEEP   3'h3
`define LCDP9_MODE_WATCH      3'h4
`define LCDP9_MODE_STANDBY    3'h5

`endif

// file: lcdp9_sync.v
// lcdp9_sync.v: two-stage synchroniser for a bus of pin levels
// assumes inputs are asynchronous to sys_clk; reset is already synchronised
`timescale 1ns/1ps
module lcdp9_sync
#(
	parameter W = 8
)
(
	// clock and reset
	input  wire         sys_clk,
	input  wire         rst_sync_b,
	// levels
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] meta_ff;

	// first stage feeds only the second stage
	always @(posedge sys_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			meta_ff  <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

// file: lcdp9_pinmux.v
// lcdp9_pinmux.v: per-pin function select between general I/O, segment and expansion outputs
// assumes all select inputs are already on the sys_clk domain
`timescale 1ns/1ps
`include "lcdp9_regs.vh"
module lcdp9_pinmux
(
	// configuration
	input  wire [3:0] segment_select_field,
	input  wire       expansion_select_bit,
	input  wire [7:0] latch,
	input  wire [7:0] dir,
	// alternate sources
	input  wire [7:0] seg_drive,
	input  wire [3:0] exp_drive,
	// resolved pin drive
	output wire [7:0] mux_out,
	output wire [7:0] mux_oe
);

	wire gpio_sel;

	assign gpio_sel = (segment_select_field == `LCDP9_SEG_GPIO);

	// one select per pin; upper four pins also carry expansion signals
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_pin
			if (i >= `LCDP9_PINS_EXP_LO)
			begin : g_exp
				// expansion select outranks segment field
				assign mux_out[i] = expansion_select_bit ? exp_drive[i-4] :
					gpio_sel ? latch[i] : seg_drive[i];
				assign mux_oe[i]  = expansion_select_bit ? 1'b1 :
					gpio_sel ? dir[i] : 1'b1;
			end
			else
			begin : g_plain
				assign mux_out[i] = gpio_sel ? latch[i] : seg_drive[i];
				assign mux_oe[i]  = gpio_sel ? dir[i] : 1'b1;
			end
		end
	endgenerate

endmodule

// file: lcdp9_port.v
// lcdp9_port.v: eight-pin general I/O port shared with LCD segment and expansion outputs
// assumes a single-cycle register port on sys_clk and LCD control from the LCD block
//
// Summary of operation
// - eight bidirectional pins, each with its own latch bit and direction bit.
// - output latch at FFDC, read/write, cleared to zero on reset.
// - direction register at FFEC, write-only, cleared on reset: all pins inputs.
// - port read returns latch bit where direction bit is one.
// - port read returns sampled pin level where direction bit is zero.
// - direction one drives pin from latch; zero turns driver off.
// - direction and latch matter to the pins only while segment field selects general I/O.
// - reading direction register always gives all ones.
// - pin 7: expansion latch clock, else I/O at 0000, else segment 40.
// - pin 6: expansion shift clock, else I/O at 0000, else segment 39.
// - pin 5: expansion display data, else I/O at 0000, else segment 38.
// - pin 4: expansion frame signal, else I/O at 0000, else segment 37.
// - pins 3..0: I/O at 0000, else segments 36 down to 33.
// - pins float in reset and standby, hold in sleep/subsleep/watch.
`timescale 1ns/1ps
`include "lcdp9_regs.vh"
module lcdp9_port
(
	// clock and reset
	input  wire                      sys_clk,
	input  wire                      rst_b,
	// register port
	input  wire [`LCDP9_ADDR_W-1:0]  reg_addr,
	input  wire [7:0]                reg_wdata,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	output reg  [7:0]                reg_rdata,
	// lcd port control fields
	input  wire [3:0]                segment_select_field,
	input  wire                      expansion_select_bit,
	// lcd driver sources, same clock
	input  wire [7:0]                seg_drive,
	input  wire                      expansion_latch_clock,
	input  wire                      expansion_shift_clock,
	input  wire                      expansion_display_data,
	input  wire                      expansion_frame_signal,
	// power mode, same clock
	input  wire [2:0]                pwr_mode,
	// pins
	input  wire [7:0]                pin_in,
	output reg  [7:0]                pin_out,
	output reg  [7:0]                pin_oe
);

	reg        rst_meta_ff;
	reg        rst_sync_ff;
	reg  [7:0] port_nine_output_latch_ff;
	reg  [7:0] port_nine_direction_ff;
	reg  [7:0] nxt_latch;
	reg  [7:0] nxt_dir;
	reg  [7:0] nxt_rdata;
	reg  [7:0] nxt_pin_out;
	reg  [7:0] nxt_pin_oe;
	wire [7:0] pin_sync;
	wire [7:0] mux_out;
	wire [7:0] mux_oe;
	wire       hold_mode;
	wire       float_mode;

	// reset release through two flops
	always @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// pin levels arrive asynchronously
	lcdp9_sync #(.W(8)) u_sync
	(
		.sys_clk    (sys_clk),
		.rst_sync_b (rst_sync_ff),
		.async_in   (pin_in),
		.sync_out   (pin_sync)
	);

	lcdp9_pinmux u_mux
	(
		.segment_select_field (segment_select_field),
		.expansion_select_bit (expansion_select_bit),
		.latch                (port_nine_output_latch_ff),
		.dir                  (port_nine_direction_ff),
		.seg_drive            (seg_drive),
		.exp_drive            ({expansion_latch_clock, expansion_shift_clock,
		                        expansion_display_data, expansion_frame_signal}),
		.mux_out              (mux_out),
		.mux_oe               (mux_oe)
	);

	assign float_mode = (pwr_mode == `LCDP9_MODE_STANDBY);
	assign hold_mode  = (pwr_mode == `LCDP9_MODE_SLEEP) ||
	                    (pwr_mode == `LCDP9_MODE_SUBSLEEP) ||
	                    (pwr_mode == `LCDP9_MODE_WATCH);

	// register writes; unmapped addresses are ignored
	always @*
	begin
		nxt_latch = port_nine_output_latch_ff;
		nxt_dir   = port_nine_direction_ff;
		if (reg_wr && (reg_addr == `LCDP9_OFS_LATCH))
			nxt_latch = reg_wdata;
		else if (reg_wr && (reg_addr == `LCDP9_OFS_DIR))
			nxt_dir = reg_wdata;
	end

	// read mux; unmapped addresses read zero
	always @*
	begin
		nxt_rdata = 8'h00;
		if (reg_rd && (reg_addr == `LCDP9_OFS_LATCH))
			nxt_rdata = (port_nine_direction_ff & port_nine_output_latch_ff) |
			            (~port_nine_direction_ff & pin_sync);
		else if (reg_rd && (reg_addr == `LCDP9_OFS_DIR))
			nxt_rdata = `LCDP9_DIR_READ;
	end

	// pin drive per power mode; hold keeps last drive as is
	always @*
	begin
		nxt_pin_out = mux_out;
		nxt_pin_oe  = mux_oe;
		if (float_mode)
		begin
			nxt_pin_out = 8'h00;
			nxt_pin_oe  = 8'h00;
		end
		else if (hold_mode)
		begin
			nxt_pin_out = pin_out;
			nxt_pin_oe  = pin_oe;
		end
	end

	// state registers; pins float while reset holds
	always @(posedge sys_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			port_nine_output_latch_ff <= `LCDP9_LATCH_RST;
			port_nine_direction_ff    <= `LCDP9_DIR_RST;
			reg_rdata                 <= 8'h00;
			pin_out                   <= 8'h00;
			pin_oe                    <= 8'h00;
		end
		else
		begin
			port_nine_output_latch_ff <= nxt_latch;
			port_nine_direction_ff    <= nxt_dir;
			reg_rdata                 <= nxt_rdata;
			pin_out                   <= nxt_pin_out;
			pin_oe                    <= nxt_pin_oe;
		end
	end

endmodule

// file: lcdp9_pins.sv
// lcdp9_pins.sv: outside world on the eight port pins
// assumes pin_oe high means the port drives the pin
`timescale 1ns/1ps
module lcdp9_pins
(
	// port drive and outside level
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe,
	input  wire [7:0] ext_lvl,
	// level seen back by the port
	output wire [7:0] pin_in
);
	// outside source wins only where the port floats
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// file: lcdp9_chk.sv
// lcdp9_chk.sv: port-level assertions for the port nine block
// assumes it is bound to lcdp9_port and sees its ports only
`timescale 1ns/1ps
`include "lcdp9_regs.vh"
module lcdp9_chk
(
	// clock, reset and register port
	input wire        sys_clk,
	input wire        rst_b,
	input wire [15:0] reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	// lcd control and sources
	input wire [3:0]  segment_select_field,
	input wire        expansion_select_bit,
	input wire [7:0]  seg_drive,
	input wire        expansion_latch_clock,
	input wire        expansion_shift_clock,
	input wire        expansion_display_data,
	input wire        expansion_frame_signal,
	input wire [2:0]  pwr_mode,
	// pins
	input wire [7:0]  pin_out,
	input wire [7:0]  pin_oe
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// running modes only; sleep freezes and standby floats the pins
	wire run_c = pwr_mode < 3'h2;
	wire gpio_c = run_c && !expansion_select_bit && segment_select_field == `LCDP9_SEG_GPIO;
	dir_ones_a:
	assert property ($past(reg_rd && reg_addr == `LCDP9_OFS_DIR) |-> reg_rdata == 8'hFF)
		else $error("direction read not all ones");
	latch_read_a:
	assert property ($past(reg_rd && reg_addr == `LCDP9_OFS_LATCH) && $past(!reg_wr && gpio_c, 2)
		|-> ((reg_rdata ^ $past(pin_out)) & $past(pin_oe)) == 8'h00) else $error("latch read");
	latch_follow_a:
	assert property (reg_wr && reg_addr == `LCDP9_OFS_LATCH && gpio_c |=> gpio_c
		##1 ((pin_out ^ $past(reg_wdata, 2)) & pin_oe) == 8'h00) else $error("pin lags latch");
	seg_route_a:
	assert property ($past(!expansion_select_bit && segment_select_field != 4'h0 && run_c)
		&& $past(rst_b, 3) |-> pin_oe == 8'hFF && pin_out == $past(seg_drive))
		else $error("segment route");
	exp_hi_a:
	assert property ($past(expansion_select_bit && run_c) && $past(rst_b, 3) |-> pin_oe[7:6] == 2'b11
		&& pin_out[7:6] == $past({expansion_latch_clock, expansion_shift_clock}))
		else $error("expansion clocks");
	exp_lo_a:
	assert property ($past(expansion_select_bit && run_c) && $past(rst_b, 3) |-> pin_oe[5:4] == 2'b11
		&& pin_out[5:4] == $past({expansion_display_data, expansion_frame_signal}))
		else $error("expansion data");
	standby_float_a:
	assert property ($past(pwr_mode) == `LCDP9_MODE_STANDBY |-> pin_oe == 8'h00)
		else $error("standby drives");
	sleep_hold_a:
	assert property ($past(pwr_mode) == `LCDP9_MODE_SLEEP |-> $stable(pin_out) && $stable(pin_oe))
		else $error("sleep moved pins");
	light_hold_a:
	assert property (($past(pwr_mode) == `LCDP9_MODE_SUBSLEEP
		|| $past(pwr_mode) == `LCDP9_MODE_WATCH) |-> $stable(pin_out) && $stable(pin_oe))
		else $error("hold mode moved pins");
	cover property (expansion_select_bit && run_c);
	cover property (pwr_mode == `LCDP9_MODE_SLEEP && reg_wr);
	cover property (reg_rd && reg_addr == `LCDP9_OFS_LATCH);
endmodule
bind lcdp9_port lcdp9_chk chk_u (.*);

// file: lcdp9_tb.sv
// lcdp9_tb.sv: register and pin tests for the port nine block
// assumes lcdp9_port with the pin model on its pins
`timescale 1ns/1ps
`include "lcdp9_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
	logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        expansion_select_bit = 1'b0, expansion_latch_clock = 1'b1;
	logic        expansion_shift_clock = 1'b0, expansion_display_data = 1'b1;
	logic        expansion_frame_signal = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, seg_drive = 8'h5A, ext_lvl = 8'hA5;
	logic [3:0]  segment_select_field = 4'h0;
	logic [2:0]  pwr_mode = 3'h0;
	wire  [7:0]  reg_rdata, pin_in, pin_out, pin_oe;
	int          n_errors = 0, checks = 0, cyc = 0;
	lcdp9_port dut_u (.*);
	lcdp9_pins pins_u (.*);
	initial forever #25 sys_clk = ~sys_clk;
	// one-cycle strobe: raised just after an edge, dropped at the taking edge
	task wr(input [15:0] a, input [7:0] d);
		begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
			#1;
		end
	endtask
	// data stands only in the cycle after the taking edge
	task rd(input [15:0] a, input [7:0] e);
		begin
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			#1 `CHK(reg_rdata, e)
		end
	endtask
	task idle(input int n);
		begin
			repeat (n) @(posedge sys_clk);
			#1;
		end
	endtask
	task stop_test;
		begin
			if (n_errors == 0 && checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// hang guard, far beyond the 66 or so cycles of the run
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			n_errors++;
			stop_test;
		end
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		idle(5);
		rd(`LCDP9_OFS_LATCH, 8'hA5);
		`CHK(pin_oe, 8'h00)
		wr(`LCDP9_OFS_DIR, 8'hF0);
		rd(`LCDP9_OFS_LATCH, 8'h05);
		wr(`LCDP9_OFS_LATCH, 8'h3C);
		rd(`LCDP9_OFS_DIR, 8'hFF);
		rd(`LCDP9_OFS_LATCH, 8'h35);
		`CHK(pin_out & pin_oe, 8'h30)
		segment_select_field <= 4'h1;
		wr(`LCDP9_OFS_LATCH, 8'hFF);
		for (int s = 1; s < 16; s++)
		begin
			segment_select_field <= s[3:0];
			idle(2);
			`CHK(pin_out & pin_oe, 8'h5A)
		end
		expansion_select_bit <= 1'b1;
		idle(2);
		`CHK(pin_out & pin_oe, 8'hBA)
		expansion_select_bit <= 1'b0;
		segment_select_field <= 4'h0;
		idle(2);
		`CHK(pin_out & pin_oe, 8'hF0)
		pwr_mode <= `LCDP9_MODE_SLEEP;
		wr(`LCDP9_OFS_LATCH, 8'h00);
		idle(2);
		`CHK(pin_out & pin_oe, 8'hF0)
		pwr_mode <= `LCDP9_MODE_SUBSLEEP;
		idle(2);
		`CHK(pin_out & pin_oe, 8'hF0)
		pwr_mode <= `LCDP9_MODE_WATCH;
		idle(2);
		`CHK(pin_out & pin_oe, 8'hF0)
		pwr_mode <= `LCDP9_MODE_STANDBY;
		idle(2);
		`CHK(pin_oe, 8'h00)
		pwr_mode <= `LCDP9_MODE_SUBACTIVE;
		idle(2);
		`CHK(pin_oe, 8'hF0)
		`CHK(pin_out & pin_oe, 8'h00)
		rst_b <= 1'b0;
		idle(1);
		`CHK(pin_oe, 8'h00)
		rst_b <= 1'b1;
		idle(5);
		rd(`LCDP9_OFS_LATCH, 8'hA5);
		stop_test;
	end
endmodule
